/* File: hdl/sclh_map.vh */
`ifndef SCLH_MAP_VH
`define SCLH_MAP_VH
// Character codes
`define SCLH_CH_BS 8'h08
`define SCLH_CH_LF 8'h0a
`define SCLH_CH_CR 8'h0d
`define SCLH_CH_XON 8'h11
`define SCLH_CH_XOFF 8'h13
`define SCLH_CH_NAK 8'h15
`define SCLH_CH_CAN 8'h18
`define SCLH_CH_ESC 8'h1b
`define SCLH_CH_SP 8'h20
`define SCLH_CH_BANG 8'h21
`define SCLH_CH_GT 8'h3e
`define SCLH_CTRL_TOP 8'h1f
// Error code posted on queue trouble, two's complement of -400
`define SCLH_ERR_QUE 16'hfe70
// Register offsets
`define SCLH_REG_CTRL 4'h0
`define SCLH_REG_BAUD 4'h1
`define SCLH_REG_STAT 4'h2
`define SCLH_REG_LINE 4'h3
// Control register field positions
`define SCLH_CTRL_ECHO 0
`define SCLH_CTRL_PACE 1
`define SCLH_CTRL_PROMPT 2
`define SCLH_CTRL_REMOTE 3
`define SCLH_CTRL_READY 4
// Reset values
`define SCLH_CTRL_RST 4'h2
`define SCLH_BAUD_LO 16'd9600
`define SCLH_BAUD_HI 16'd19200
// Sizes
`define SCLH_LINE_MAX 8'd127
`define SCLH_TXQ_DEPTH 16
`define SCLH_TXQ_AW 4
`endif

/* File: hdl/sclh_txq.v */
`timescale 1ns/10ps
`default_nettype none
// Transmit character queue; overflow drops the byte and pulses ovf.
module sclh_txq #(
	parameter W = 8,
	parameter AW = 4
) (
	input wire ref_clk, // clock
	input wire sys_rst, // sync reset
	input wire flush, // empty the queue
	input wire wr, // push strobe
	input wire [W-1:0] wdata, // pushed byte
	input wire rd, // pop strobe
	output wire [W-1:0] rdata, // head byte
	output wire empty, // no data
	output wire full, // no room
	output reg ovf // push lost
);
	reg [W-1:0] mem [0:(1<<AW)-1];
	reg [AW:0] wp_q;
	reg [AW:0] rp_q;
	assign empty = (wp_q == rp_q);
	assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
	assign rdata = mem[rp_q[AW-1:0]];
	always @(posedge ref_clk) begin
		if (wr && !full)
			mem[wp_q[AW-1:0]] <= wdata;
	end
	always @(posedge ref_clk) begin
		if (sys_rst || flush) begin
			wp_q <= {(AW+1){1'b0}};
			rp_q <= {(AW+1){1'b0}};
			ovf <= 1'b0;
		end else begin
			ovf <= wr && full;
			if (wr && !full)
				wp_q <= wp_q + 1'b1;
			if (rd && !empty)
				rp_q <= rp_q + 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: hdl/sclh_sync.v */
`timescale 1ns/10ps
`default_nettype none
// Two-stage synchroniser for a pin level
module sclh_sync (
	input wire ref_clk, // clock
	input wire sys_rst, // sync reset
	input wire pin, // asynchronous level
	output reg sync_q // synchronised level
);
	reg meta_q;
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= pin;
			sync_q <= meta_q;
		end
	end
endmodule
`default_nettype wire

/* File: hdl/sclh_line.v */
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "sclh_map.vh"
//////////////////////////////////////////////////////////////////////////////
// Operation
// - Of control codes 00-1f only CR, LF, BS, ESC, XON, XOFF, CAN act.
// - Backspace removes the last buffered character, never a terminator.
// - CR or LF ends the line and hands it to the parser.
// - After the parser finishes a line, send CR LF.
// - ESC empties the input buffer and answers CR LF.
// - With pacing on, XON resumes and XOFF halts transmission.
// - CAN resets receive and transmit pointers and both queues.
// - XOFF halt posts queue error -400.
// - XON after halt drains pending data, then sends an exclamation mark.
// - Echo BS as BS SP BS; echo only first of CR LF or LF CR.
// - With pacing, terminator answers XOFF CR with echo, else XOFF.
// - Echo mode returns every received byte from 20 up, plus BS and terminators; ESC clears the line.
// - Lost echo through overflow sends NAK and posts -400.
// - With prompt on, send CR LF > when ready for the next command.
// - Baud rate comes up 9600 or 19200 per power-up switch; writable later.
// - Echo enable is immediate; disable waits for next terminator; reset keeps it.
// - With pacing and prompt both off, echo is forced on.
// - Prompt plus echo: echo every character and prompt when ready.
// - Output-changing commands run only in remote mode.
module sclh_line #(
	parameter LINE_MAX = 127,
	parameter AW = `SCLH_TXQ_AW
) (
	input wire ref_clk, // 125 MHz clock
	input wire sys_rst, // sync reset, active high
	input wire power_up_baud_switch, // strap pin
	input wire rx_valid, // received byte strobe
	input wire [7:0] rx_data, // received byte
	input wire tx_ready, // UART can take a byte
	output reg tx_valid, // byte to UART strobe
	output reg [7:0] tx_data, // byte to UART
	output reg line_valid, // line complete pulse
	output reg [7:0] line_len, // characters in line
	input wire [6:0] line_raddr, // parser read address
	output reg [7:0] line_rdata, // parser read data
	input wire parse_done, // parser dispatched line
	input wire cmd_output, // parser command changes output
	output reg cmd_allow, // output command may run
	output reg err_valid, // post to error queue
	output reg [15:0] err_code, // posted code
	output reg [15:0] baud_rate, // current baud rate
	input wire [3:0] reg_addr, // register address
	input wire [7:0] reg_wdata, // write data
	input wire reg_wr, // write strobe
	input wire reg_rd, // read strobe
	output reg [15:0] reg_rdata // read data, next cycle
);
	// Sequencer states
	localparam S_IDLE = 3'd0;
	localparam S_BS2 = 3'd1;
	localparam S_BS3 = 3'd2;
	localparam S_CR = 3'd3;
	localparam S_LF = 3'd4;
	localparam S_GT = 3'd5;
	localparam S_WAIT = 3'd6;
	localparam S_ECR = 3'd7;

	function is_term;
		input [7:0] c;
		begin
			is_term = (c == `SCLH_CH_CR) || (c == `SCLH_CH_LF);
		end
	endfunction

	wire strap_s;
	reg [7:0] buf_q [0:LINE_MAX-1];
	reg [7:0] cnt_q;
	reg echo_q, pace_q, prompt_q, remote_q, echo_off_pend_q;
	reg halted_q, bang_pend_q, last_term_q;
	reg [7:0] last_q;
	reg [2:0] st_q;
	reg [1:0] tail_q;
	reg [1:0] strap_wait_q;
	reg push;
	reg [7:0] push_d;
	reg flush;
	wire [7:0] q_head;
	wire q_empty, q_full, q_ovf;
	wire is_ctrl = rx_data <= `SCLH_CTRL_TOP;
	wire echo_eff = echo_q || (!pace_q && !prompt_q);
	wire pop = tx_valid && tx_ready;
	wire can_rx = rx_valid && rx_data == `SCLH_CH_CAN;
	// Second terminator of a CR LF or LF CR pair
	wire pair_2nd = is_term(rx_data) && last_term_q && last_q != rx_data;

	sclh_sync u_strap (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.pin(power_up_baud_switch),
		.sync_q(strap_s)
	);

	sclh_txq #(.W(8), .AW(AW)) u_txq (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.flush(flush),
		.wr(push),
		.wdata(push_d),
		.rd(pop),
		.rdata(q_head),
		.empty(q_empty),
		.full(q_full),
		.ovf(q_ovf)
	);

	//////////////////////////////////////////////////////////////////////////////
	// Output byte chooser: one push per cycle, sequencer has priority
	// over direct echo since echo bytes arrive far slower than the clock.
	always @* begin
		push = 1'b0;
		push_d = 8'h00;
		flush = can_rx;
		case (st_q)
		S_BS2: begin
			push = 1'b1;
			push_d = `SCLH_CH_SP;
		end
		S_BS3: begin
			push = 1'b1;
			push_d = `SCLH_CH_BS;
		end
		S_CR: begin
			push = 1'b1;
			push_d = `SCLH_CH_CR;
		end
		S_LF: begin
			push = 1'b1;
			push_d = `SCLH_CH_LF;
		end
		S_ECR: begin
			push = 1'b1;
			push_d = `SCLH_CH_CR;
		end
		S_GT: begin
			push = 1'b1;
			push_d = `SCLH_CH_GT;
		end
		default: begin
			if (q_ovf && echo_eff) begin
				push = 1'b1;
				push_d = `SCLH_CH_NAK;
			end else if (rx_valid && !can_rx) begin
				if (!is_ctrl && echo_eff) begin
					push = 1'b1;
					push_d = rx_data;
				end else if (rx_data == `SCLH_CH_BS && echo_eff) begin
					push = 1'b1;
					push_d = `SCLH_CH_BS;
				end else if (is_term(rx_data) && pace_q && !pair_2nd) begin
					push = 1'b1;
					push_d = `SCLH_CH_XOFF;
				end else if (is_term(rx_data) && echo_eff &&
					!(last_term_q && last_q != rx_data)) begin
					push = 1'b1;
					push_d = rx_data;
				end
			end
		end
		endcase
	end

	//////////////////////////////////////////////////////////////////////////////
	// Receive side, line buffer and sequencer
	always @(posedge ref_clk) begin
		if (rx_valid && !is_ctrl && cnt_q < LINE_MAX)
			buf_q[cnt_q[6:0]] <= rx_data;
		line_rdata <= buf_q[line_raddr];
	end

	always @(posedge ref_clk) begin
		if (sys_rst) begin
			cnt_q <= 8'h00;
			st_q <= S_IDLE;
			tail_q <= 2'd0;
			line_valid <= 1'b0;
			line_len <= 8'h00;
			last_q <= 8'h00;
			last_term_q <= 1'b0;
			err_valid <= 1'b0;
			err_code <= 16'h0000;
		end else begin
			line_valid <= 1'b0;
			err_valid <= 1'b0;
			err_code <= `SCLH_ERR_QUE;
			if (q_ovf)
				err_valid <= 1'b1;
			case (st_q)
			S_BS2: st_q <= S_BS3;
			S_BS3: st_q <= S_IDLE;
			S_CR: st_q <= S_LF;
			S_LF: st_q <= (tail_q == 2'd1 && prompt_q) ? S_GT : S_IDLE;
			S_GT: st_q <= S_IDLE;
			S_ECR: st_q <= S_WAIT;
			S_WAIT: begin
				if (parse_done) begin
					st_q <= S_CR;
					tail_q <= 2'd1;
				end
			end
			default: st_q <= S_IDLE;
			endcase
			if (rx_valid) begin
				last_q <= rx_data;
				last_term_q <= is_term(rx_data) && !(last_term_q && last_q != rx_data);
				if (can_rx) begin
					cnt_q <= 8'h00;
					st_q <= S_IDLE;
				end else if (!is_ctrl) begin
					if (cnt_q < LINE_MAX)
						cnt_q <= cnt_q + 8'd1;
				end else if (rx_data == `SCLH_CH_BS) begin
					// Terminators are never buffered, so any held byte may go
					if (cnt_q != 8'h00)
						cnt_q <= cnt_q - 8'd1;
					if (echo_eff)
						st_q <= S_BS2;
				end else if (rx_data == `SCLH_CH_ESC) begin
					cnt_q <= 8'h00;
					st_q <= S_CR;
					tail_q <= 2'd0;
				end else if (is_term(rx_data)) begin
					// Second half of a CR LF pair carries no line of its own
					if (!(last_term_q && last_q != rx_data)) begin
						line_valid <= 1'b1;
						line_len <= cnt_q;
						cnt_q <= 8'h00;
						st_q <= (pace_q && echo_eff) ? S_ECR : S_WAIT;
					end
				end
				// Other control codes fall through untouched
			end
			if (halted_q == 1'b0 && rx_valid && rx_data == `SCLH_CH_XOFF && pace_q) begin
				err_valid <= 1'b1;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Transmit pacing
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			halted_q <= 1'b0;
			bang_pend_q <= 1'b0;
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
		end else begin
			if (rx_valid && pace_q && rx_data == `SCLH_CH_XOFF)
				halted_q <= 1'b1;
			else if (rx_valid && pace_q && rx_data == `SCLH_CH_XON) begin
				halted_q <= 1'b0;
				if (halted_q)
					bang_pend_q <= 1'b1;
			end
			if (!pace_q)
				halted_q <= 1'b0;
			if (can_rx)
				bang_pend_q <= 1'b0;
			if (pop) begin
				tx_valid <= 1'b0;
			end else if (!tx_valid && !halted_q && !can_rx) begin
				if (!q_empty) begin
					tx_valid <= 1'b1;
					tx_data <= q_head;
				end else if (bang_pend_q) begin
					tx_valid <= 1'b1;
					tx_data <= `SCLH_CH_BANG;
					bang_pend_q <= 1'b0;
				end
			end
		end
	end
	// Head is popped when the byte is handed over, so tx_data holds a copy.

	//////////////////////////////////////////////////////////////////////////////
	// Configuration registers; sys_rst models power-up, not the reset command
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			echo_q <= 1'b0;
			pace_q <= 1'b1;
			prompt_q <= 1'b0;
			remote_q <= 1'b0;
			echo_off_pend_q <= 1'b0;
			baud_rate <= `SCLH_BAUD_LO;
			strap_wait_q <= 2'd0;
			cmd_allow <= 1'b0;
			reg_rdata <= 16'h0000;
		end else begin
			cmd_allow <= cmd_output && remote_q;
			// Synchroniser is cleared by reset, so wait until it has refilled
			if (strap_wait_q != 2'd3)
				strap_wait_q <= strap_wait_q + 2'd1;
			if (strap_wait_q == 2'd2)
				baud_rate <= strap_s ? `SCLH_BAUD_HI : `SCLH_BAUD_LO;
			if (rx_valid && is_term(rx_data) && echo_off_pend_q) begin
				echo_q <= 1'b0;
				echo_off_pend_q <= 1'b0;
			end
			if (reg_wr) begin
				case (reg_addr)
				`SCLH_REG_CTRL: begin
					pace_q <= reg_wdata[`SCLH_CTRL_PACE];
					prompt_q <= reg_wdata[`SCLH_CTRL_PROMPT];
					remote_q <= reg_wdata[`SCLH_CTRL_REMOTE];
					if (reg_wdata[`SCLH_CTRL_ECHO]) begin
						echo_q <= 1'b1;
						echo_off_pend_q <= 1'b0;
					end else if (echo_q)
						echo_off_pend_q <= 1'b1;
				end
				`SCLH_REG_BAUD: baud_rate <= reg_wdata[0] ? `SCLH_BAUD_HI : `SCLH_BAUD_LO;
				default: begin
				end
				endcase
			end
			reg_rdata <= 16'h0000;
			if (reg_rd) begin
				case (reg_addr)
				`SCLH_REG_CTRL: reg_rdata <= {11'h000, echo_off_pend_q, remote_q,
					prompt_q, pace_q, echo_eff};
				`SCLH_REG_BAUD: reg_rdata <= baud_rate;
				`SCLH_REG_STAT: reg_rdata <= {12'h000, bang_pend_q, q_full, q_empty, halted_q};
				`SCLH_REG_LINE: reg_rdata <= {8'h00, cnt_q};
				default: reg_rdata <= 16'h0000;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

/* File: bench/sclh_line_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module sclh_line_chk (
	input wire logic ref_clk, // clock
	input wire logic sys_rst, // reset
	input wire logic rx_valid, // rx strobe
	input wire logic [7:0] rx_data, // rx byte
	input wire logic tx_ready, // tx sink
	input wire logic tx_valid, // tx strobe
	input wire logic [7:0] tx_data, // tx byte
	input wire logic line_valid, // line end
	input wire logic cmd_output, // cmd wish
	input wire logic cmd_allow, // cmd gate
	input wire logic err_valid, // error post
	input wire logic [15:0] err_code, // error
	input wire logic [15:0] baud_rate // baud
);
	logic [7:0] last_q;
	wire logic is_term = rx_data == 8'h0d || rx_data == 8'h0a;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			last_q <= 8'h00;
		else if (rx_valid)
			last_q <= rx_data;
	end
	////////////////////////////////
	a_line_cause: assert property (line_valid |-> $past(rx_valid && is_term))
		else $error("line end without terminator");
	// CR xor LF is 07, so this picks the other terminator of a pair
	a_pair_once: assert property (rx_valid && is_term && (last_q ^ rx_data) == 8'h07 |=> !line_valid)
		else $error("second terminator ended a line");
	a_err_code: assert property (err_valid |-> err_code == 16'hfe70)
		else $error("wrong error code");
	a_err_once: assert property (err_valid |=> !err_valid)
		else $error("error post too long");
	a_cmd_gate: assert property (cmd_allow |-> $past(cmd_output))
		else $error("command allowed without request");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("pending byte dropped");
	a_baud_rst: assert property (disable iff (1'b0) sys_rst ##1 sys_rst |-> baud_rate == 16'd9600)
		else $error("baud not default in reset");
	a_baud_set: assert property (baud_rate == 16'd9600 || baud_rate == 16'd19200)
		else $error("baud out of set");
	a_ctl_drop: assert property (rx_valid && rx_data < 8'h20 &&
		!(rx_data inside {8'h08, 8'h0a, 8'h0d, 8'h11, 8'h13, 8'h18, 8'h1b}) |=> !line_valid && !err_valid)
		else $error("idle control code acted");
endmodule
bind sclh_line sclh_line_chk sclh_line_chk_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .rx_valid(rx_valid),
	.rx_data(rx_data), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .line_valid(line_valid),
	.cmd_output(cmd_output), .cmd_allow(cmd_allow), .err_valid(err_valid), .err_code(err_code),
	.baud_rate(baud_rate));
`default_nettype wire

/* File: bench/sclh_host.sv */
`timescale 1ns/10ps
`default_nettype none
module sclh_host (
	input wire logic ref_clk, // clock
	output logic rx_valid, // byte strobe
	output logic [7:0] rx_data, // byte
	output logic tx_ready, // can take
	input wire logic tx_valid, // device strobe
	input wire logic [7:0] tx_data // device byte
);
	logic [7:0] got[$];
	logic paused = 1'b0;
	logic [1:0] ph = 2'd0;
	int stuck = 0;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b1;
	end
	// Stall one cycle in three so the device must hold its byte
	always @(posedge ref_clk) begin
		ph <= (ph == 2'd2) ? 2'd0 : ph + 2'd1;
		tx_ready <= ph != 2'd2;
		if (tx_valid && tx_ready) begin
			got.push_back(tx_data);
			if (tx_data == 8'h13)
				paused <= 1'b1;
			// No XON follows a parsed line, so its closing LF or prompt reopens
			if (tx_data == 8'h11 || tx_data == 8'h0a || tx_data == 8'h3e)
				paused <= 1'b0;
		end
	end
	task automatic send(input logic [7:0] b);
		for (int i = 0; i < 300 && paused; i++)
			@(posedge ref_clk);
		if (paused)
			stuck++;
		rx_valid <= 1'b1;
		rx_data <= b;
		@(posedge ref_clk);
		rx_valid <= 1'b0;
		rx_data <= ~b;
		repeat (5) @(posedge ref_clk);
	endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic ref_clk, sys_rst, strap, rx_valid, tx_ready, tx_valid, line_valid;
	logic parse_done, cmd_output, cmd_allow, err_valid, reg_wr, reg_rd;
	logic [7:0] rx_data, tx_data, line_len, line_rdata, reg_wdata;
	logic [6:0] line_raddr;
	logic [3:0] reg_addr;
	logic [15:0] err_code, baud_rate, reg_rdata, err_last;
	logic [31:0] seed = 32'd43510;
	logic [7:0] sent[0:15];
	int n_mismatch = 0;
	int total_checks = 0;
	int n_lines = 0;
	int i, k, len;
	sclh_line sclh_line_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .power_up_baud_switch(strap),
		.rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
		.line_valid(line_valid), .line_len(line_len), .line_raddr(line_raddr), .line_rdata(line_rdata),
		.parse_done(parse_done), .cmd_output(cmd_output), .cmd_allow(cmd_allow), .err_valid(err_valid),
		.err_code(err_code), .baud_rate(baud_rate), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	sclh_host sclh_host_inst (.ref_clk(ref_clk), .rx_valid(rx_valid), .rx_data(rx_data),
		.tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data));
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (line_valid)
			n_lines <= n_lines + 1;
		if (err_valid)
			err_last <= err_code;
	end
	////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic end_sim;
		$display("Checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rchk(input string w, input logic [3:0] a, input logic [15:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(w, e, reg_rdata);
		@(posedge ref_clk);
	endtask
	task automatic snd(input logic [31:0] v, input int n);
		for (int j = n - 1; j >= 0; j--)
			sclh_host_inst.send(v[8*j +: 8]);
	endtask
	task automatic xtx(input string w, input logic [31:0] e, input int n);
		int j;
		for (j = 0; j < 300 && sclh_host_inst.got.size() < n; j++)
			@(posedge ref_clk);
		// Extra cycles expose bytes beyond the expected count
		repeat (12) @(posedge ref_clk);
		chk(w, 16'(n), 16'(sclh_host_inst.got.size()));
		for (j = 0; j < n && j < sclh_host_inst.got.size(); j++)
			chk(w, {8'h00, e[8*(n-1-j) +: 8]}, {8'h00, sclh_host_inst.got[j]});
		if (sclh_host_inst.got.size() < n)
			end_sim;
		sclh_host_inst.got.delete();
	endtask
	task automatic par;
		parse_done <= 1'b1;
		@(posedge ref_clk);
		parse_done <= 1'b0;
		@(posedge ref_clk);
	endtask
	initial begin
		sys_rst = 1'b1;
		strap = 1'b0;
		parse_done = 1'b0;
		cmd_output = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		line_raddr = 7'h00;
		err_last = 16'h0000;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		rchk("ctrl", 4'h0, 16'h0002);
		rchk("baud", 4'h1, 16'd9600);
		rchk("unmapped", 4'h9, 16'h0000);
		for (k = 0; k < 3; k++) begin
			seed = xs(seed);
			len = 1 + seed[3:0];
			for (i = 0; i < len; i++) begin
				seed = xs(seed);
				sent[i] = 8'h21 + 8'(seed[15:8] % 94);
				sclh_host_inst.send(sent[i]);
			end
			snd(32'h0d, 1);
			chk("lines", 16'(k + 1), 16'(n_lines));
			chk("len", 16'(len), {8'h00, line_len});
			for (i = 0; i < len; i++) begin
				line_raddr <= 7'(i);
				@(posedge ref_clk);
				#1 chk("buf", {8'h00, sent[i]}, {8'h00, line_rdata});
				@(posedge ref_clk);
			end
			xtx("pace", 32'h13, 1);
			par;
			xtx("done", 32'h0d0a, 2);
		end
		snd(32'h0a, 1);
		chk("pair", 16'd3, 16'(n_lines));
		xtx("pair", 32'h0, 0);
		snd(32'h6162, 2);
		rchk("count", 4'h3, 16'h0002);
		snd(32'h1b, 1);
		xtx("esc", 32'h0d0a, 2);
		rchk("count", 4'h3, 16'h0000);
		snd(32'h131b, 2);
		chk("err", 16'hfe70, err_last);
		xtx("halted", 32'h0, 0);
		snd(32'h11, 1);
		xtx("resume", 32'h0d0a21, 3);
		err_last <= 16'h0000;
		snd(32'h131b6162, 4);
		chk("err", 16'hfe70, err_last);
		snd(32'h18, 1);
		rchk("count", 4'h3, 16'h0000);
		snd(32'h11, 1);
		xtx("cancel", 32'h21, 1);
		wr(4'h0, 8'h03);
		snd(32'h7808, 2);
		xtx("bs", 32'h78082008, 4);
		rchk("count", 4'h3, 16'h0000);
		snd(32'h01, 1);
		xtx("ctl", 32'h0, 0);
		rchk("count", 4'h3, 16'h0000);
		wr(4'h0, 8'h02);
		rchk("ctrl", 4'h0, 16'h0013);
		snd(32'h7a0d, 2);
		xtx("echo off", 32'h7a130d, 3);
		rchk("ctrl", 4'h0, 16'h0002);
		par;
		xtx("done", 32'h0d0a, 2);
		wr(4'h0, 8'h05);
		snd(32'h6b, 1);
		xtx("echo", 32'h6b, 1);
		snd(32'h0d, 1);
		xtx("echo", 32'h0d, 1);
		par;
		xtx("prompt", 32'h0d0a3e, 3);
		sys_rst <= 1'b1;
		strap <= 1'b1;
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rchk("baud", 4'h1, 16'd19200);
		wr(4'h1, 8'h00);
		rchk("baud", 4'h1, 16'd9600);
		wr(4'h0, 8'h00);
		rchk("ctrl", 4'h0, 16'h0001);
		wr(4'h0, 8'h08);
		cmd_output <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk("allow", 16'h0001, {15'h0, cmd_allow});
		wr(4'h0, 8'h00);
		repeat (2) @(posedge ref_clk);
		chk("allow", 16'h0000, {15'h0, cmd_allow});
		chk("stuck", 16'h0000, 16'(sclh_host_inst.stuck));
		end_sim;
	end
endmodule
`default_nettype wire
